// *** inc/txcfg_pkg.sv ***
// register map, fields, reset values and timing of the config bank
//
// Functional notes
// (R1) preset mode: clock pin drives 800kHz while active
// (R2) i2c mode: clock pin is scl input only
// (R3) 3-wire spi: clock pin drives 800kHz while active
// (R4) 4-wire spi: clock pin carries read data out
// (R5) boost only effective under serial register control
// (R6) boost bit raises amp on-time 25% to 50%
// (R7) idle after transmit enters selected power-down state
// (R8) shutdown is the default power-down state
// (R9) standby keeps crystal; program keeps crystal and pll
// (R10) power-down field: 00 shutdown, 01 standby, 10 program
// (R11) 5-bit capacitance trim, reset to zero
// (R12) vco select: 0 ring default, 1 lc
// (R13) band divider 00 ring; lc 11/10/01 bands
// (R14) host restores vco select and divider together
// (R15) identification register returns fixed code
// (R16) identification code differs per interface variant
// (R17) revision register returns fixed code for checks
// (R18) read-only registers ignore writes
// (R19) boost bit resets to zero
package txcfg_pkg;
    ////////////////////////////////////////
    // register offsets (7-bit address space)
    localparam logic [6:0] TXCFG_ADDR_POWERDOWN_CONFIG = 7'h03;
    localparam logic [6:0] TXCFG_ADDR_SHUTDOWN_BOOST = 7'h05;
    localparam logic [6:0] TXCFG_ADDR_AMP_CAP_TRIM = 7'h07;
    localparam logic [6:0] TXCFG_ADDR_SYNTH_VCO = 7'h08;
    localparam logic [6:0] TXCFG_ADDR_RO_A = 7'h14;
    localparam logic [6:0] TXCFG_ADDR_RO_B = 7'h15;
    localparam logic [6:0] TXCFG_ADDR_RO_C = 7'h16;
    localparam logic [6:0] TXCFG_ADDR_CHIP_ID = 7'h1B;
    localparam logic [6:0] TXCFG_ADDR_CHIP_REV = 7'h1C;
    localparam logic [6:0] TXCFG_ADDR_STATUS = 7'h1D;
    ////////////////////////////////////////
    // field positions
    localparam int TXCFG_PWDN_LSB = 0;
    localparam int TXCFG_BOOST_BIT = 2;
    localparam int TXCFG_CAP_LSB = 0;
    localparam int TXCFG_VCO_SEL_BIT = 0;
    localparam int TXCFG_DIV_LSB = 1;
    localparam int TXCFG_STAT_TX_BIT = 0;
    localparam int TXCFG_STAT_XO_BIT = 1;
    localparam int TXCFG_STAT_PLL_BIT = 2;
    ////////////////////////////////////////
    // power-down states
    typedef enum logic [1:0]
    {
        TXCFG_PD_SHUTDOWN = 2'b00,
        TXCFG_PD_STANDBY = 2'b01,
        TXCFG_PD_PROGRAM = 2'b10,
        TXCFG_PD_RESERVED = 2'b11
    } txcfg_pd_e;
    // band divider codes
    localparam logic [1:0] TXCFG_DIV_RING = 2'b00;
    localparam logic [1:0] TXCFG_DIV_LC_HIGH = 2'b01;
    localparam logic [1:0] TXCFG_DIV_LC_MID = 2'b10;
    localparam logic [1:0] TXCFG_DIV_LC_LOW = 2'b11;
    ////////////////////////////////////////
    // reset values
    localparam logic [1:0] TXCFG_PWDN_RESET = 2'b00;
    localparam logic TXCFG_BOOST_RESET = 1'b0;
    localparam logic [4:0] TXCFG_CAP_RESET = 5'h00;
    localparam logic TXCFG_VCO_RESET = 1'b0;
    localparam logic [1:0] TXCFG_DIV_RESET = 2'b00;
    ////////////////////////////////////////
    // spi framing: read flag and address byte, then data byte
    localparam int TXCFG_SPI_RW_BIT = 7;
    localparam logic [4:0] TXCFG_SPI_ADDR_END = 5'd7;
    localparam logic [4:0] TXCFG_SPI_DATA_START = 5'd8;
    localparam logic [4:0] TXCFG_SPI_FRAME_END = 5'd15;
    localparam logic [4:0] TXCFG_SPI_DONE = 5'd16;
    ////////////////////////////////////////
    // timing of the clock output
    localparam int TXCFG_SYS_CLK_KHZ = 200000;
    localparam int TXCFG_CLOCK_OUTPUT_PIN_KHZ = 800;
    localparam int TXCFG_CLOCK_OUTPUT_PIN_HALF = TXCFG_SYS_CLK_KHZ / (2 * TXCFG_CLOCK_OUTPUT_PIN_KHZ);
endpackage

// *** verilog/txcfg_sync.sv ***
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module txcfg_sync
#(
    parameter logic RESET_VAL = 1'b0
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pin_in,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_r; // first stage, read only by s2_r
    logic s2_r;
    logic s3_r;
    logic agree;
    ////////////////////////////////////////
    // shift chain; only the second stage reads the first
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign agree = (s2_r == s3_r);
    ////////////////////////////////////////
    // filtered level and one-cycle edge pulses
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            level <= RESET_VAL;
            rise <= 1'b0;
            fall <= 1'b0;
        end
        else
        begin
            rise <= agree & s3_r & ~level;
            fall <= agree & ~s3_r & level;
            // a change counts only once two stages agree
            if (agree)
            begin
                level <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/txcfg_bank.sv ***
// transmitter configuration register bank with spi slave and clock output pin
`timescale 1ns/1ps
`default_nettype none
module txcfg_bank
    import txcfg_pkg::*;
#(
    parameter bit SPI_VARIANT = 1'b1,
    parameter logic [7:0] ID_SPI = 8'hA5, // arbitrary value
    parameter logic [7:0] ID_I2C = 8'h5A, // arbitrary value
    parameter logic [7:0] REV_CODE = 8'h3C, // arbitrary value
    parameter int CLOCK_OUTPUT_PIN_HALF = TXCFG_CLOCK_OUTPUT_PIN_HALF
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic device_active,
    input wire logic tx_active,
    input wire logic preset_mode_pin,
    input wire logic spi_four_wire_pin,
    input wire logic spi_csb_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic clock_output_pin_i,
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe,
    output logic scl_level,
    output logic [1:0] powerdown_state_select,
    output logic amp_duty_boost,
    output logic [4:0] output_cap_trim,
    output logic vco_type_select,
    output logic [1:0] band_divider_select,
    output logic xo_enable,
    output logic pll_enable
);
    ////////////////////////////////////////
    // pin synchronisers
    logic csb_n_lvl; // chip select after filter
    logic csb_fall; // frame start
    logic sclk_rise; // sample edge
    logic sclk_fall; // launch edge
    logic mosi_lvl; // data in
    logic four_wire_lvl; // interface width strap
    logic preset_lvl; // preset strap

    txcfg_sync #(.RESET_VAL(1'b1)) u_csb
    (
        .clk(clk),
        .srst(srst),
        .pin_in(spi_csb_n),
        .level(csb_n_lvl),
        .rise(),
        .fall(csb_fall)
    );
    txcfg_sync #(.RESET_VAL(1'b0)) u_sclk
    (
        .clk(clk),
        .srst(srst),
        .pin_in(spi_sclk),
        .level(),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );
    txcfg_sync #(.RESET_VAL(1'b0)) u_mosi
    (
        .clk(clk),
        .srst(srst),
        .pin_in(spi_mosi),
        .level(mosi_lvl),
        .rise(),
        .fall()
    );
    txcfg_sync #(.RESET_VAL(1'b0)) u_four
    (
        .clk(clk),
        .srst(srst),
        .pin_in(spi_four_wire_pin),
        .level(four_wire_lvl),
        .rise(),
        .fall()
    );
    txcfg_sync #(.RESET_VAL(1'b0)) u_preset
    (
        .clk(clk),
        .srst(srst),
        .pin_in(preset_mode_pin),
        .level(preset_lvl),
        .rise(),
        .fall()
    );
    // in i2c mode the clock pin is the scl input, handed to the i2c engine
    txcfg_sync #(.RESET_VAL(1'b1)) u_scl
    (
        .clk(clk),
        .srst(srst),
        .pin_in(clock_output_pin_i),
        .level(scl_level),
        .rise(),
        .fall()
    );

    ////////////////////////////////////////
    // register storage, defined field bits only
    logic [1:0] pwdn_r;
    logic boost_r;
    logic [4:0] cap_r;
    logic vco_r;
    logic [1:0] div_r;

    // spi frame state
    logic [4:0] bit_cnt_r; // bits taken in this frame, saturates at 16
    logic [7:0] shift_in_r; // incoming bits, msb first
    logic read_r; // frame is a read
    logic [6:0] addr_r; // frame address
    logic [7:0] shift_out_r; // outgoing read data
    logic wr_strobe; // last data bit of a write frame sampled
    logic [7:0] wr_data;
    logic [7:0] rd_data;

    assign wr_data = {shift_in_r[6:0], mosi_lvl};
    assign wr_strobe = SPI_VARIANT & ~csb_n_lvl & sclk_rise & ~read_r
        & (bit_cnt_r == TXCFG_SPI_FRAME_END);

    ////////////////////////////////////////
    // read mux; unmapped addresses read as zero
    always_comb
    begin
        rd_data = 8'h00;
        unique case (addr_r)
            TXCFG_ADDR_POWERDOWN_CONFIG:
                rd_data[TXCFG_PWDN_LSB +: 2] = pwdn_r;
            TXCFG_ADDR_SHUTDOWN_BOOST:
                rd_data[TXCFG_BOOST_BIT] = boost_r;
            TXCFG_ADDR_AMP_CAP_TRIM:
                rd_data[TXCFG_CAP_LSB +: 5] = cap_r;
            TXCFG_ADDR_SYNTH_VCO:
            begin
                rd_data[TXCFG_VCO_SEL_BIT] = vco_r;
                rd_data[TXCFG_DIV_LSB +: 2] = div_r;
            end
            // fixed code, chosen by interface variant
            TXCFG_ADDR_CHIP_ID:
                rd_data = SPI_VARIANT ? ID_SPI : ID_I2C; // (R15) (R16)
            TXCFG_ADDR_CHIP_REV:
                rd_data = REV_CODE; // (R17)
            // live state of the power manager
            TXCFG_ADDR_STATUS:
            begin
                rd_data[TXCFG_STAT_TX_BIT] = tx_active;
                rd_data[TXCFG_STAT_XO_BIT] = xo_enable;
                rd_data[TXCFG_STAT_PLL_BIT] = pll_enable;
            end
            default:
                rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////
    // spi receive: bit counter, address capture
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bit_cnt_r <= 5'd0;
            shift_in_r <= 8'h00;
            read_r <= 1'b0;
            addr_r <= 7'h00;
        end
        else if (csb_fall)
        begin
            // new frame restarts the counter
            bit_cnt_r <= 5'd0;
            read_r <= 1'b0;
        end
        else if (~csb_n_lvl && sclk_rise && bit_cnt_r != TXCFG_SPI_DONE)
        begin
            shift_in_r <= {shift_in_r[6:0], mosi_lvl};
            bit_cnt_r <= bit_cnt_r + 5'd1;
            // first byte complete: read flag and address
            if (bit_cnt_r == TXCFG_SPI_ADDR_END)
            begin
                read_r <= shift_in_r[TXCFG_SPI_RW_BIT - 1];
                addr_r <= {shift_in_r[5:0], mosi_lvl};
            end
        end
    end

    ////////////////////////////////////////
    // spi transmit: load on the first falling edge of the data byte
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_out_r <= 8'h00;
        end
        else if (~csb_n_lvl && sclk_fall && read_r)
        begin
            if (bit_cnt_r == TXCFG_SPI_DATA_START)
            begin
                shift_out_r <= rd_data;
            end
            else
            begin
                shift_out_r <= {shift_out_r[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////
    // register writes; read-only and unmapped addresses ignore writes
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pwdn_r <= TXCFG_PWDN_RESET; // (R8)
            boost_r <= TXCFG_BOOST_RESET; // (R19)
            cap_r <= TXCFG_CAP_RESET; // (R11)
            vco_r <= TXCFG_VCO_RESET; // (R12)
            div_r <= TXCFG_DIV_RESET; // (R13)
        end
        else if (wr_strobe)
        begin
            unique case (addr_r)
                TXCFG_ADDR_POWERDOWN_CONFIG:
                    pwdn_r <= wr_data[TXCFG_PWDN_LSB +: 2]; // (R10)
                TXCFG_ADDR_SHUTDOWN_BOOST:
                    boost_r <= wr_data[TXCFG_BOOST_BIT]; // (R6)
                TXCFG_ADDR_AMP_CAP_TRIM:
                    cap_r <= wr_data[TXCFG_CAP_LSB +: 5]; // (R11)
                TXCFG_ADDR_SYNTH_VCO:
                begin
                    vco_r <= wr_data[TXCFG_VCO_SEL_BIT]; // (R12)
                    div_r <= wr_data[TXCFG_DIV_LSB +: 2]; // (R13)
                end
                default:
                    pwdn_r <= pwdn_r; // (R18)
            endcase
        end
    end

    ////////////////////////////////////////
    // field outputs to the analog side
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            powerdown_state_select <= TXCFG_PWDN_RESET;
            amp_duty_boost <= 1'b0;
            output_cap_trim <= TXCFG_CAP_RESET;
            vco_type_select <= TXCFG_VCO_RESET;
            band_divider_select <= TXCFG_DIV_RESET;
        end
        else
        begin
            powerdown_state_select <= pwdn_r;
            // preset straps hold the amp at quarter on-time
            amp_duty_boost <= boost_r & ~(~SPI_VARIANT & preset_lvl); // (R5) (R6)
            output_cap_trim <= cap_r;
            vco_type_select <= vco_r;
            // ring oscillator ignores the divider
            band_divider_select <= vco_r ? div_r : TXCFG_DIV_RING; // (R13)
        end
    end

    ////////////////////////////////////////
    // power manager: idle enters the selected state; 11 acts as shutdown
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            xo_enable <= 1'b0; // (R8)
            pll_enable <= 1'b0;
        end
        else if (tx_active)
        begin
            xo_enable <= 1'b1;
            pll_enable <= 1'b1;
        end
        else
        begin
            // preset parts always park in shutdown
            if (~SPI_VARIANT & preset_lvl)
            begin
                xo_enable <= 1'b0; // (R8)
                pll_enable <= 1'b0;
            end
            else
            begin
                xo_enable <= (pwdn_r == TXCFG_PD_STANDBY) | (pwdn_r == TXCFG_PD_PROGRAM); // (R7) (R9)
                pll_enable <= (pwdn_r == TXCFG_PD_PROGRAM); // (R9)
            end
        end
    end

    ////////////////////////////////////////
    // 800khz square wave, held low and phase-reset while inactive
    logic [$clog2(CLOCK_OUTPUT_PIN_HALF)-1:0] div_cnt_r;
    logic sq_r;
    always_ff @(posedge clk)
    begin
        if (srst || !device_active)
        begin
            div_cnt_r <= '0;
            sq_r <= 1'b0;
        end
        else if (div_cnt_r == ($clog2(CLOCK_OUTPUT_PIN_HALF))'(CLOCK_OUTPUT_PIN_HALF - 1))
        begin
            div_cnt_r <= '0;
            sq_r <= ~sq_r; // (R1) (R3)
        end
        else
        begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////
    // clock pin role selection, registered
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            clock_output_pin_o <= 1'b0;
            clock_output_pin_oe <= 1'b0;
        end
        else if (SPI_VARIANT && four_wire_lvl)
        begin
            // drive read data only while a read byte shifts
            clock_output_pin_o <= shift_out_r[7]; // (R4)
            clock_output_pin_oe <= ~csb_n_lvl & read_r
                & (bit_cnt_r >= TXCFG_SPI_DATA_START); // (R4)
        end
        else if (SPI_VARIANT || preset_lvl)
        begin
            clock_output_pin_o <= sq_r; // (R1) (R3)
            clock_output_pin_oe <= 1'b1;
        end
        else
        begin
            // i2c mode: pin is scl, never driven
            clock_output_pin_o <= 1'b0; // (R2)
            clock_output_pin_oe <= 1'b0; // (R2)
        end
    end
endmodule
`default_nettype wire

// *** verif/txcfg_bank_asserts.sv ***
// port-level checks of the transmitter configuration bank
`timescale 1ns/1ps
`default_nettype none
module txcfg_bank_asserts
#(
    parameter bit SPI_VARIANT = 1'b1,
    parameter int CLOCK_OUTPUT_PIN_HALF = 4
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic device_active,
    input wire logic tx_active,
    input wire logic preset_mode_pin,
    input wire logic spi_four_wire_pin,
    input wire logic spi_csb_n,
    input wire logic clock_output_pin_i,
    input wire logic clock_output_pin_o,
    input wire logic clock_output_pin_oe,
    input wire logic scl_level,
    input wire logic [1:0] powerdown_state_select,
    input wire logic amp_duty_boost,
    input wire logic [4:0] output_cap_trim,
    input wire logic vco_type_select,
    input wire logic [1:0] band_divider_select,
    input wire logic xo_enable,
    input wire logic pll_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    logic [15:0] gap_r; // cycles since the clock pin last changed
    logic gap_ok_r; // a change was already seen in steady running
    logic pin_q_r; // pin value one cycle back
    // gap counter, cleared while the clock should not run
    always_ff @(posedge clk)
    begin
        pin_q_r <= clock_output_pin_o;
        if (srst || !device_active || !clock_output_pin_oe)
        begin
            gap_r <= 16'h0000;
            gap_ok_r <= 1'b0;
        end
        else if (pin_q_r != clock_output_pin_o)
        begin
            gap_r <= 16'h0000;
            gap_ok_r <= 1'b1;
        end
        else
            gap_r <= gap_r + 16'h0001;
    end
    ////////////////////////////////////////
    // power-down field steady, no transmission
    sequence s_pd_held;
        (!tx_active && $stable(powerdown_state_select))[*2];
    endsequence
    chk_pd_map: assert property (s_pd_held |->
        xo_enable == (powerdown_state_select inside {2'b01, 2'b10})
        && pll_enable == (powerdown_state_select == 2'b10))
        else $error("power-down decode wrong");
    chk_tx_keeps_on: assert property (tx_active |=> xo_enable && pll_enable)
        else $error("oscillators off while transmitting");
    chk_clk_period: assert property ($changed(clock_output_pin_o) && device_active
        && clock_output_pin_oe && gap_ok_r |-> gap_r == CLOCK_OUTPUT_PIN_HALF - 1)
        else $error("clock output half period wrong");
    chk_clk_stall: assert property (device_active && clock_output_pin_oe
        |-> gap_r <= CLOCK_OUTPUT_PIN_HALF + 4)
        else $error("clock output stopped toggling");
    chk_clk_idle: assert property ((!device_active && !spi_four_wire_pin
        && clock_output_pin_oe)[*3] |-> !clock_output_pin_o)
        else $error("clock output not low while inactive");
    chk_i2c_release: assert property ((!SPI_VARIANT && !preset_mode_pin)[*6]
        |-> !clock_output_pin_oe)
        else $error("clock pin driven in i2c mode");
    chk_scl_follow: assert property ((!SPI_VARIANT && $stable(clock_output_pin_i))[*8]
        |-> scl_level == clock_output_pin_i)
        else $error("scl level does not follow pin");
    chk_preset_boost: assert property ((!SPI_VARIANT && preset_mode_pin)[*6]
        |-> !amp_duty_boost)
        else $error("boost active in preset mode");
    chk_four_wire_oe: assert property ((SPI_VARIANT && spi_four_wire_pin && spi_csb_n)[*8]
        |-> !clock_output_pin_oe)
        else $error("pin driven outside read in 4-wire");
    chk_three_wire_oe: assert property ((SPI_VARIANT && !spi_four_wire_pin)[*8]
        |-> clock_output_pin_oe)
        else $error("pin not driven in 3-wire");
    chk_ring_divider: assert property (!vco_type_select |-> band_divider_select == 2'b00)
        else $error("ring oscillator with nonzero divider");
    chk_reset_vals: assert property ($fell(srst) |-> powerdown_state_select == 2'b00
        && !amp_duty_boost && output_cap_trim == 5'h00 && !vco_type_select)
        else $error("fields not at reset value");
endmodule
bind txcfg_bank txcfg_bank_asserts
#(
    .SPI_VARIANT(SPI_VARIANT),
    .CLOCK_OUTPUT_PIN_HALF(CLOCK_OUTPUT_PIN_HALF)
)
chk_i
(
    .clk(clk), .srst(srst), .device_active(device_active), .tx_active(tx_active),
    .preset_mode_pin(preset_mode_pin), .spi_four_wire_pin(spi_four_wire_pin),
    .spi_csb_n(spi_csb_n), .clock_output_pin_i(clock_output_pin_i),
    .clock_output_pin_o(clock_output_pin_o), .clock_output_pin_oe(clock_output_pin_oe),
    .scl_level(scl_level), .powerdown_state_select(powerdown_state_select),
    .amp_duty_boost(amp_duty_boost), .output_cap_trim(output_cap_trim),
    .vco_type_select(vco_type_select), .band_divider_select(band_divider_select),
    .xo_enable(xo_enable), .pll_enable(pll_enable)
);
`default_nettype wire

// *** verif/txcfg_host.sv ***
// serial host model sending 16-bit register frames to the bank
`timescale 1ns/1ps
`default_nettype none
module txcfg_host
(
    input wire logic clk,
    output logic csb_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso
);
    // idle bus: deselected, serial clock parked low
    initial
    begin
        csb_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end
    // wait n clocks, then step off the edge
    task automatic ph(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one frame, msb first; 12 + 13 clocks give a 125 ns serial period
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
        output logic [7:0] rdat);
        logic [15:0] f;
        f = {rd, a, wd};
        rdat = 8'h00;
        csb_n = 1'b0;
        ph(13);
        for (int i = 15; i >= 0; i--)
        begin
            mosi = f[i];
            ph(12);
            // read data is caught at the rising edge that takes it
            if (i < 8)
                rdat[i] = miso;
            sclk = 1'b1;
            ph(13);
            sclk = 1'b0;
        end
        ph(12);
        csb_n = 1'b1;
        // a released data line must not hold its last value
        mosi = ~mosi;
        ph(25);
    endtask
endmodule
`default_nettype wire

// *** verif/test_tx_config_register_bank.sv ***
// self-checking bench for the transmitter configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_tx_config_register_bank;
    import txcfg_pkg::*;
    localparam int HALF = 4; // shortened clock output half period
    localparam int TOG = 80 / HALF; // pin changes seen in 80 cycles
    localparam logic [7:0] ID_S = 8'h3E; // arbitrary value
    localparam logic [7:0] ID_I = 8'hC4; // arbitrary value
    localparam logic [7:0] REV = 8'h71; // arbitrary value
    localparam int LIMIT = 40000; // run ceiling
    logic clk, srst, dev_act, tx_act, preset2, four_w, scl2;
    logic csb_n, sclk, mosi, pin_o, pin_oe, pin2_o, pin2_oe, scl2_lvl, boost2;
    logic boost, vco, xo, pll;
    logic [1:0] pd_sel, div, pd, dv;
    logic [4:0] trim;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int n1, n2;
    // the spi variant's pin resolves with a pull-up when undriven; the i2c variant's pin takes scl2
    wire pin_i = pin_oe ? pin_o : 1'b1;
    wire pin2_i = pin2_oe ? pin2_o : scl2;
    ////////////////////////////////////////
    txcfg_bank #(.SPI_VARIANT(1'b1), .ID_SPI(ID_S), .ID_I2C(ID_I), .REV_CODE(REV),
        .CLOCK_OUTPUT_PIN_HALF(HALF)) uut
    (
        .clk(clk), .srst(srst), .device_active(dev_act), .tx_active(tx_act),
        .preset_mode_pin(preset2), .spi_four_wire_pin(four_w), .spi_csb_n(csb_n),
        .spi_sclk(sclk), .spi_mosi(mosi), .clock_output_pin_i(pin_i),
        .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe), .scl_level(),
        .powerdown_state_select(pd_sel), .amp_duty_boost(boost), .output_cap_trim(trim),
        .vco_type_select(vco), .band_divider_select(div), .xo_enable(xo), .pll_enable(pll)
    );
    // i2c variant: strap picks preset or scl
    txcfg_bank #(.SPI_VARIANT(1'b0), .CLOCK_OUTPUT_PIN_HALF(HALF)) uut_i2c
    (
        .clk(clk), .srst(srst), .device_active(dev_act), .tx_active(tx_act),
        .preset_mode_pin(preset2), .spi_four_wire_pin(1'b0), .spi_csb_n(csb_n),
        .spi_sclk(sclk), .spi_mosi(mosi), .clock_output_pin_i(pin2_i),
        .clock_output_pin_o(pin2_o), .clock_output_pin_oe(pin2_oe), .scl_level(scl2_lvl),
        .powerdown_state_select(), .amp_duty_boost(boost2), .output_cap_trim(),
        .vco_type_select(), .band_divider_select(), .xo_enable(), .pll_enable()
    );
    txcfg_host host (.clk(clk), .csb_n(csb_n), .sclk(sclk), .mosi(mosi), .miso(pin_i));
    ////////////////////////////////////////
    // 200 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            errors++;
            end_of_test;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer(1'b0, a, d, r);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] r;
        host.xfer(1'b1, a, 8'h00, r);
        chk($sformatf("register %h", a), exp, r);
    endtask
    // count pin changes over 80 cycles
    task automatic count_tog(output int a, output int b);
        logic pa, pb;
        a = 0;
        b = 0;
        pa = pin_o;
        pb = pin2_o;
        repeat (80)
        begin
            tick(1);
            a += int'(pin_o !== pa);
            b += int'(pin2_o !== pb);
            pa = pin_o;
            pb = pin2_o;
        end
    endtask
    task end_of_test;
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        srst = 1'b1;
        dev_act = 1'b0;
        tx_act = 1'b0;
        preset2 = 1'b0;
        four_w = 1'b1;
        scl2 = 1'b1;
        tick(6);
        srst = 1'b0;
        tick(8);
        // reset values
        rdc(TXCFG_ADDR_POWERDOWN_CONFIG, 8'h00);
        rdc(TXCFG_ADDR_SHUTDOWN_BOOST, 8'h00);
        rdc(TXCFG_ADDR_AMP_CAP_TRIM, 8'h00);
        rdc(TXCFG_ADDR_SYNTH_VCO, 8'h00);
        // read-only and unmapped ignore writes
        wr(TXCFG_ADDR_CHIP_ID, 8'hFF);
        wr(TXCFG_ADDR_CHIP_REV, 8'h00);
        wr(7'h40, 8'hFF);
        rdc(TXCFG_ADDR_CHIP_ID, ID_S);
        rdc(TXCFG_ADDR_CHIP_REV, REV);
        rdc(7'h40, 8'h00);
        // power-down codes 00, 01 and 10 around a transmission
        for (int i = 0; i < 3; i++)
        begin
            pd = 2'(i);
            wr(TXCFG_ADDR_POWERDOWN_CONFIG, {6'h00, pd});
            chk("select", {6'h00, pd}, {6'h00, pd_sel});
            chk("xo pll", {6'h00, pd != 2'b00, pd == 2'b10}, {6'h00, xo, pll});
            tx_act = 1'b1;
            tick(2);
            chk("tx xo pll", 8'h03, {6'h00, xo, pll});
            tx_act = 1'b0;
            tick(2);
            chk("after tx", {6'h00, pd != 2'b00, pd == 2'b10}, {6'h00, xo, pll});
        end
        wr(TXCFG_ADDR_SHUTDOWN_BOOST, 8'h04);
        chk("boost", 8'h01, {7'h00, boost});
        rdc(TXCFG_ADDR_SHUTDOWN_BOOST, 8'h04);
        wr(TXCFG_ADDR_AMP_CAP_TRIM, 8'h1F);
        chk("trim", 8'h1F, {3'h0, trim});
        // every lc band, then back to the ring oscillator
        for (int d = 3; d > 0; d--)
        begin
            dv = 2'(d);
            wr(TXCFG_ADDR_SYNTH_VCO, {5'h00, dv, 1'b1});
            chk("vco div", {5'h00, dv, 1'b1}, {5'h00, div, vco});
            rdc(TXCFG_ADDR_SYNTH_VCO, {5'h00, dv, 1'b1});
        end
        wr(TXCFG_ADDR_SYNTH_VCO, 8'h00);
        chk("ring", 8'h00, {5'h00, div, vco});
        // clock output in 3-wire and in preset mode
        four_w = 1'b0;
        preset2 = 1'b1;
        dev_act = 1'b1;
        tick(20);
        count_tog(n1, n2);
        chk("drive", 8'h03, {6'h00, pin_oe, pin2_oe});
        chk("3-wire toggles", 8'(TOG), n1[7:0]);
        chk("preset toggles", 8'(TOG), n2[7:0]);
        chk("preset boost", 8'h00, {7'h00, boost2});
        dev_act = 1'b0;
        tick(10);
        chk("idle pins", 8'h00, {6'h00, pin_o, pin2_o});
        // 4-wire idle and i2c mode release the pin
        four_w = 1'b1;
        preset2 = 1'b0;
        tick(12);
        chk("released", 8'h00, {6'h00, pin_oe, pin2_oe});
        scl2 = 1'b0;
        tick(10);
        chk("scl low", 8'h00, {7'h00, scl2_lvl});
        scl2 = 1'b1;
        tick(10);
        chk("scl high", 8'h01, {7'h00, scl2_lvl});
        end_of_test;
    end
endmodule
`default_nettype wire
